// *** peripheral_clock_gating_group1.sv ***
`timescale 1ns/1ps
// How it works
// [R1] each enable bit gates exactly one peripheral clock on or off
// [R2] access to a gated-off unit answers with a bus fault
// [R3] all enable bits reset to zero, units start unclocked
// [R4] run, sleep and deep-sleep registers; power state picks one
// [R5] sleep registers act only when auto gating bit is set
// [R6] reserved bits read zero and ignore writes
// [R7] bits 18, 17, 16 gate general counters 2, 1, 0
// [R8] bit 14 two-wire port 1, bit 12 port 0, bit 13 reserved
// [R9] bit 9 quadrature decoder 1, bit 8 decoder 0
// [R10] bit 5 sync serial 1, bit 4 sync serial 0, bit 3 reserved
// [R11] bits 2, 1, 0 gate async serial ports 2, 1, 0
// [R12] deep-sleep register sits at offset 0x124, resets to zero
// [R13] gate switching is glitch free, no truncated clock pulses
module peripheral_clock_gating_group1
	import clock_gate_pkg::*;
(
	input  wire logic              mclk_i,
	input  wire logic              rstn_i,
	input  wire logic              ce_i,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              unit_req_i,
	input  wire logic [UNIT_N-1:0] unit_sel_i,
	output logic                   unit_fault_o,
	output logic [UNIT_N-1:0]      unit_clk_o,
	output logic [UNIT_N-1:0]      unit_on_o,
	output logic                   irq_o
);
	logic rst_meta_r;
	logic rst_n_r;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	logic [DATA_W-1:0] run_gate_r;
	logic [DATA_W-1:0] sleep_gate_r;
	logic [DATA_W-1:0] deep_gate_r;
	logic [DATA_W-1:0] run_cfg_r;
	power_state_type   power_r;
	logic [1:0]        irq_status_r;
	logic [1:0]        irq_enable_r;

	// write channel capture, either order
	logic              aw_held_r;
	logic              w_held_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic [DATA_W-1:0] w_data_r;
	logic [3:0]        w_strb_r;

	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take  = s_axi_wvalid & s_axi_wready;
	wire [ADDR_W-1:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
	wire [DATA_W-1:0] wr_data = w_held_r ? w_data_r : s_axi_wdata;
	wire [3:0]        wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
	wire aw_have = aw_held_r | aw_take;
	wire w_have  = w_held_r | w_take;
	wire wr_fire = ce_i & aw_have & w_have & ~s_axi_bvalid;

	function automatic logic [DATA_W-1:0] strb_merge(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [3:0] strb, input logic [DATA_W-1:0] mask);
		logic [DATA_W-1:0] bytes;
		bytes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		strb_merge = ((old_v & ~bytes) | (new_v & bytes)) & mask; // see [R6]
	endfunction

	wire sel_run   = (wr_addr == RUN_GATE_OFS);
	wire sel_sleep = (wr_addr == SLEEP_GATE_OFS);
	wire sel_deep  = (wr_addr == DEEP_GATE_OFS); // see [R12]
	wire sel_cfg   = (wr_addr == RUN_CFG_OFS);
	wire sel_pwr   = (wr_addr == POWER_CTRL_OFS);
	wire sel_ien   = (wr_addr == IRQ_ENABLE_OFS);
	wire sel_iclr  = (wr_addr == IRQ_CLEAR_OFS);
	wire sel_ist   = (wr_addr == IRQ_STATUS_OFS);
	wire wr_known  = sel_run | sel_sleep | sel_deep | sel_cfg | sel_pwr | sel_ien | sel_iclr | sel_ist;

	wire [DATA_W-1:0] run_nxt   = strb_merge(run_gate_r, wr_data, wr_strb, GATE_WRITE_MASK);
	wire [DATA_W-1:0] sleep_nxt = strb_merge(sleep_gate_r, wr_data, wr_strb, GATE_WRITE_MASK);
	wire [DATA_W-1:0] deep_nxt  = strb_merge(deep_gate_r, wr_data, wr_strb, GATE_WRITE_MASK);
	wire [DATA_W-1:0] cfg_nxt   = strb_merge(run_cfg_r, wr_data, wr_strb, RUN_CFG_MASK);

	always_ff @(posedge mclk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			aw_addr_r <= '0;
			w_data_r  <= '0;
			w_strb_r  <= '0;
		end else if (ce_i) begin
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
			end else begin
				if (aw_take) begin
					aw_held_r <= 1'b1;
					aw_addr_r <= s_axi_awaddr;
				end
				if (w_take) begin
					w_held_r <= 1'b1;
					w_data_r <= s_axi_wdata;
					w_strb_r <= s_axi_wstrb;
				end
			end
		end
	end

	assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid & rst_n_r;
	assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid & rst_n_r;

	always_ff @(posedge mclk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (ce_i) begin
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// gating and configuration registers
	always_ff @(posedge mclk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			run_gate_r   <= GATE_RESET; // see [R3]
			sleep_gate_r <= GATE_RESET;
			deep_gate_r  <= GATE_RESET; // see [R12]
			run_cfg_r    <= RUN_CFG_RESET;
			power_r      <= PWR_RUN;
			irq_enable_r <= IRQ_RESET;
		end else if (wr_fire) begin
			if (sel_run)
				run_gate_r <= run_nxt; // see [R7] [R8] [R9] [R10] [R11]
			if (sel_sleep)
				sleep_gate_r <= sleep_nxt;
			if (sel_deep)
				deep_gate_r <= deep_nxt;
			if (sel_cfg)
				run_cfg_r <= cfg_nxt;
			if (sel_pwr && wr_strb[0]) begin
				unique case (wr_data[1:0])
					2'b01:   power_r <= PWR_SLEEP;
					2'b11:   power_r <= PWR_DEEP;
					default: power_r <= PWR_RUN;
				endcase
			end
			if (sel_ien && wr_strb[0])
				irq_enable_r <= wr_data[1:0];
		end
	end

	// active register selection
	wire auto_gating = run_cfg_r[AUTO_GATING_POS];
	logic [DATA_W-1:0] active_gate;
	always_comb begin
		active_gate = run_gate_r;
		if (auto_gating) begin // see [R5]
			unique case (power_r)
				PWR_SLEEP: active_gate = sleep_gate_r; // see [R4]
				PWR_DEEP:  active_gate = deep_gate_r;
				default:   active_gate = run_gate_r;
			endcase
		end
	end

	gate_ctrl_if gate_bus ();
	assign gate_bus.want_on = gate_pack(active_gate); // see [R1]
	assign gate_bus.enable  = ce_i;

	unit_clock_gate u_gate (
		.mclk_i     (mclk_i),
		.rst_n_i    (rst_n_r),
		.ctl        (gate_bus.gate),
		.unit_clk_o (unit_clk_o)
	);

	logic fault_now;
	bus_fault_check u_fault (
		.unit_on_i    (gate_bus.unit_on),
		.unit_sel_i   (unit_sel_i),
		.unit_req_i   (unit_req_i),
		.unit_fault_o (fault_now)
	);

	logic [UNIT_N-1:0] unit_on_r;
	logic              fault_r;
	logic [1:0]        power_prev_r;
	always_ff @(posedge mclk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			unit_on_r    <= '0;
			fault_r      <= 1'b0;
			power_prev_r <= PWR_RUN;
		end else if (ce_i) begin
			unit_on_r    <= gate_bus.unit_on;
			fault_r      <= fault_now; // see [R2]
			power_prev_r <= power_r;
		end
	end
	assign unit_on_o    = unit_on_r;
	assign unit_fault_o = fault_r;

	// sticky events, set wins over clear
	wire [1:0] irq_set = {power_prev_r != power_r, fault_now};
	wire [1:0] irq_clr = (wr_fire && sel_iclr && wr_strb[0]) ? wr_data[1:0] : 2'b00;
	logic irq_r;
	always_ff @(posedge mclk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			irq_status_r <= IRQ_RESET;
			irq_r        <= 1'b0;
		end else if (ce_i) begin
			irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
			irq_r        <= |(((irq_status_r & ~irq_clr) | irq_set) & irq_enable_r);
		end
	end
	assign irq_o = irq_r;

	// read channel
	logic [DATA_W-1:0] rd_data;
	logic              rd_ok;
	always_comb begin
		rd_ok   = 1'b1;
		rd_data = '0;
		unique case (s_axi_araddr)
			RUN_GATE_OFS:   rd_data = run_gate_r; // see [R6]
			SLEEP_GATE_OFS: rd_data = sleep_gate_r;
			DEEP_GATE_OFS:  rd_data = deep_gate_r;
			RUN_CFG_OFS:    rd_data = run_cfg_r;
			POWER_CTRL_OFS: rd_data = {30'h0000_0000, power_r};
			IRQ_STATUS_OFS: rd_data = {30'h0000_0000, irq_status_r};
			IRQ_ENABLE_OFS: rd_data = {30'h0000_0000, irq_enable_r};
			IRQ_CLEAR_OFS:  rd_data = '0;
			default:        rd_ok = 1'b0;
		endcase
	end

	assign s_axi_arready = ~s_axi_rvalid & rst_n_r;
	always_ff @(posedge mclk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (ce_i) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_data;
				s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// *** clock_gate_pkg.sv ***
package clock_gate_pkg;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned UNIT_N = 12;

	// register byte offsets
	localparam logic [ADDR_W-1:0] RUN_GATE_OFS    = 12'h104;
	localparam logic [ADDR_W-1:0] SLEEP_GATE_OFS  = 12'h114;
	localparam logic [ADDR_W-1:0] DEEP_GATE_OFS   = 12'h124;
	localparam logic [ADDR_W-1:0] RUN_CFG_OFS     = 12'h060;
	localparam logic [ADDR_W-1:0] POWER_CTRL_OFS  = 12'h180;
	localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS  = 12'h190;
	localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFS  = 12'h194;
	localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFS   = 12'h198;

	// gate field positions
	localparam int unsigned GP_COUNTER2_POS   = 18;
	localparam int unsigned GP_COUNTER1_POS   = 17;
	localparam int unsigned GP_COUNTER0_POS   = 16;
	localparam int unsigned TWO_WIRE1_POS     = 14;
	localparam int unsigned TWO_WIRE0_POS     = 12;
	localparam int unsigned QUAD_DEC1_POS     = 9;
	localparam int unsigned QUAD_DEC0_POS     = 8;
	localparam int unsigned SYNC_SERIAL1_POS  = 5;
	localparam int unsigned SYNC_SERIAL0_POS  = 4;
	localparam int unsigned ASYNC_SERIAL2_POS = 2;
	localparam int unsigned ASYNC_SERIAL1_POS = 1;
	localparam int unsigned ASYNC_SERIAL0_POS = 0;

	localparam logic [DATA_W-1:0] GATE_WRITE_MASK = 32'h0007_5337;
	localparam logic [DATA_W-1:0] GATE_RESET      = 32'h0000_0000;
	localparam int unsigned       AUTO_GATING_POS = 27;
	localparam logic [DATA_W-1:0] RUN_CFG_MASK    = 32'h0800_0000;
	localparam logic [DATA_W-1:0] RUN_CFG_RESET   = 32'h0000_0000;

	// irq bits: bus fault on gated unit, power state change
	localparam int unsigned IRQ_FAULT_POS  = 0;
	localparam int unsigned IRQ_POWER_POS  = 1;
	localparam logic [1:0]  IRQ_RESET      = 2'h0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		PWR_RUN   = 2'b00,
		PWR_SLEEP = 2'b01,
		PWR_DEEP  = 2'b11
	} power_state_type;

	function automatic logic [UNIT_N-1:0] gate_pack(input logic [DATA_W-1:0] r);
		gate_pack = {r[GP_COUNTER2_POS], r[GP_COUNTER1_POS], r[GP_COUNTER0_POS],
			r[TWO_WIRE1_POS], r[TWO_WIRE0_POS], r[QUAD_DEC1_POS], r[QUAD_DEC0_POS],
			r[SYNC_SERIAL1_POS], r[SYNC_SERIAL0_POS], r[ASYNC_SERIAL2_POS],
			r[ASYNC_SERIAL1_POS], r[ASYNC_SERIAL0_POS]};
	endfunction

endpackage

// *** gate_ctrl_if.sv ***
`timescale 1ns/1ps
interface gate_ctrl_if;
	import clock_gate_pkg::*;
	logic [UNIT_N-1:0] want_on;
	logic [UNIT_N-1:0] unit_on;
	logic              enable;

	modport ctrl (output want_on, output enable, input unit_on);
	modport gate (input want_on, input enable, output unit_on);
endinterface

// *** unit_clock_gate.sv ***
`timescale 1ns/1ps
module unit_clock_gate
	import clock_gate_pkg::*;
(
	input  wire logic      mclk_i,
	input  wire logic      rst_n_i,
	gate_ctrl_if.gate      ctl,
	output logic [UNIT_N-1:0] unit_clk_o
);
	logic [UNIT_N-1:0] on_r;
	logic [UNIT_N-1:0] latch_r;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			on_r <= '0;
		else if (ctl.enable)
			on_r <= ctl.want_on;
	end

	// latch open while clock low: no glitch or runt pulse
	always_latch begin
		if (!mclk_i)
			latch_r = on_r; // see [R13]
	end

	assign unit_clk_o = {UNIT_N{mclk_i}} & latch_r; // see [R1]
	assign ctl.unit_on = on_r;
endmodule

// *** bus_fault_check.sv ***
`timescale 1ns/1ps
module bus_fault_check
	import clock_gate_pkg::*;
(
	input  wire logic [UNIT_N-1:0] unit_on_i,
	input  wire logic [UNIT_N-1:0] unit_sel_i,
	input  wire logic              unit_req_i,
	output logic                   unit_fault_o
);
	assign unit_fault_o = unit_req_i & |(unit_sel_i & ~unit_on_i); // see [R2]
endmodule

// *** peripheral_clock_gating_group1_props.sv ***
`timescale 1ns/1ps
module gating_props
	import clock_gate_pkg::*;
(
	input wire logic              mclk_i,
	input wire logic              rstn_i,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic              unit_req_i,
	input wire logic [UNIT_N-1:0] unit_sel_i,
	input wire logic              unit_fault_o,
	input wire logic [UNIT_N-1:0] unit_clk_o,
	input wire logic [UNIT_N-1:0] unit_on_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	a_fault_gated: assert property ((unit_req_i && (unit_sel_i & unit_on_o) == '0 ##1 $stable(unit_on_o))
		|-> unit_fault_o) else $error("no fault on gated unit");
	a_fault_clocked: assert property ((unit_req_i && unit_sel_i != '0 && (unit_sel_i & ~unit_on_o) == '0
		##1 $stable(unit_on_o)) |-> !unit_fault_o) else $error("fault on clocked unit");
	a_fault_idle: assert property (!unit_req_i |=> !unit_fault_o) else $error("fault without request");
	a_reset_gates: assert property ($rose(rstn_i) |-> unit_on_o == '0 [*3]) else $error("unit on after reset");
	a_on_by_write: assert property ($changed(unit_on_o) |->
		$past(s_axi_bvalid, 1) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3)) else $error("gate moved alone");
	// sampled just before the rising edge, i.e. in the low phase
	a_clk_low: assert property (@(posedge mclk_i) disable iff (!rstn_i) unit_clk_o == '0)
		else $error("gated clock high in low phase");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> s_axi_bvalid) else $error("write not answered");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	c_fault: cover property (unit_req_i ##1 unit_fault_o);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_gate_on: cover property ($rose(unit_on_o[UNIT_N-1]));
endmodule
bind peripheral_clock_gating_group1 gating_props u_props (.mclk_i, .rstn_i, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .unit_req_i, .unit_sel_i, .unit_fault_o, .unit_clk_o, .unit_on_o);

// *** periph_model.sv ***
`timescale 1ns/1ps
module periph_model
	import clock_gate_pkg::*;
(
	input  wire logic              mclk_i,
	input  wire logic              go_i,
	input  wire logic [UNIT_N-1:0] sel_i,
	input  wire logic [UNIT_N-1:0] unit_clk_i,
	output logic                   unit_req_o,
	output logic [UNIT_N-1:0]      unit_sel_o,
	output logic [7:0]             ticks_o [UNIT_N]
);
	initial begin
		unit_req_o = 1'b0;
		unit_sel_o = '0;
		for (int k = 0; k < UNIT_N; k++) ticks_o[k] = 8'h00;
	end
	// idle select flips so a stale target is never seen
	always @(posedge mclk_i) begin
		unit_req_o <= go_i;
		unit_sel_o <= go_i ? sel_i : ~unit_sel_o;
	end
	// each unit counts the clock edges it receives
	for (genvar g = 0; g < UNIT_N; g++) begin : cnt
		always @(posedge unit_clk_i[g]) ticks_o[g] <= ticks_o[g] + 8'h01;
	end
endmodule

// *** test_peripheral_clock_gating_group1.sv ***
`timescale 1ns/1ps
module test_peripheral_clock_gating_group1
	import clock_gate_pkg::*;
;
	localparam int POS [12] = '{0, 1, 2, 4, 5, 8, 9, 12, 14, 16, 17, 18};
	logic mclk_i = 0, rstn_i = 0, ce_i = 1, go = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic unit_req_i, unit_fault_o, irq_o;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [UNIT_N-1:0] psel = '0, unit_sel_i, unit_clk_o, unit_on_o;
	logic [7:0] ticks [UNIT_N];
	logic [7:0] t0, t1;
	int fail_count = 0, samples_checked = 0, i, j;
	always #12.5 mclk_i = ~mclk_i;
	peripheral_clock_gating_group1 dut_u (.mclk_i, .rstn_i, .ce_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.unit_req_i, .unit_sel_i, .unit_fault_o, .unit_clk_o, .unit_on_o, .irq_o);
	periph_model model_u (.mclk_i, .go_i(go), .sel_i(psel), .unit_clk_i(unit_clk_o), .unit_req_o(unit_req_i),
		.unit_sel_o(unit_sel_i), .ticks_o(ticks));
	task give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask
	// handshakes judged on settled values in the low phase, taken at the next rising edge
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic aw_go, w_go, b_go;
		logic [1:0] resp;
		@(posedge mclk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(negedge mclk_i);
			aw_go = s_axi_awvalid & s_axi_awready;
			w_go = s_axi_wvalid & s_axi_wready;
			b_go = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge mclk_i);
			if (aw_go) s_axi_awvalid <= 1'b0;
			if (w_go) s_axi_wvalid <= 1'b0;
			if (b_go) break;
		end
		s_axi_bready <= 1'b0;
		if (n == 40) begin
			fail_count++;
			give_verdict();
		end
		chk(resp, er);
	endtask
	task rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
		int n;
		logic ar_go, r_go;
		logic [1:0] resp;
		@(posedge mclk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(negedge mclk_i);
			ar_go = s_axi_arvalid & s_axi_arready;
			r_go = s_axi_rvalid;
			resp = s_axi_rresp;
			d = s_axi_rdata;
			@(posedge mclk_i);
			if (ar_go) s_axi_arvalid <= 1'b0;
			if (r_go) break;
		end
		s_axi_rready <= 1'b0;
		if (n == 40) begin
			fail_count++;
			give_verdict();
		end
		chk(resp, er);
	endtask
	task setchk(input logic [11:0] a, input logic [31:0] d, input logic [11:0] exp);
		wr(a, d, RESP_OKAY);
		repeat (3) @(posedge mclk_i);
		@(negedge mclk_i);
		chk(unit_on_o, exp);
	endtask
	task poke(input logic [11:0] s, input logic f);
		@(posedge mclk_i);
		go <= 1'b1;
		psel <= s;
		@(posedge mclk_i);
		go <= 1'b0;
		@(posedge mclk_i);
		#1 chk(unit_fault_o, f);
	endtask
	initial begin
		repeat (6) @(posedge mclk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		rd(RUN_GATE_OFS, rv, RESP_OKAY); chk(rv, 32'h0000_0000);
		rd(SLEEP_GATE_OFS, rv, RESP_OKAY); chk(rv, 32'h0000_0000);
		rd(DEEP_GATE_OFS, rv, RESP_OKAY); chk(rv, 32'h0000_0000);
		chk(unit_on_o, 32'h0000_0000);
		$display("reset values done");
		wr(RUN_GATE_OFS, 32'hffff_ffff, RESP_OKAY);
		rd(RUN_GATE_OFS, rv, RESP_OKAY); chk(rv, 32'h0007_5337);
		wr(DEEP_GATE_OFS, 32'hffff_ffff, RESP_OKAY);
		rd(DEEP_GATE_OFS, rv, RESP_OKAY); chk(rv, 32'h0007_5337);
		wr(12'h7f0, 32'h0000_0001, RESP_SLVERR);
		rd(12'h7f0, rv, RESP_SLVERR);
		$display("fields done");
		for (i = 0; i < 12; i++) begin
			j = (i + 1) % 12;
			setchk(RUN_GATE_OFS, 32'h1 << POS[i], 12'h001 << i);
			t0 = ticks[i];
			t1 = ticks[j];
			repeat (8) @(posedge mclk_i);
			@(negedge mclk_i);
			chk(8'(ticks[i] - t0), 32'h0000_0008);
			chk(8'(ticks[j] - t1), 32'h0000_0000);
			poke(12'h001 << i, 1'b0);
			poke(12'h001 << j, 1'b1);
		end
		$display("unit gates done");
		wr(SLEEP_GATE_OFS, 32'h0000_0001, RESP_OKAY);
		wr(DEEP_GATE_OFS, 32'h0000_0002, RESP_OKAY);
		setchk(RUN_GATE_OFS, 32'h0000_0004, 12'h004);
		setchk(POWER_CTRL_OFS, 32'h0000_0001, 12'h004);
		setchk(RUN_CFG_OFS, 32'h0800_0000, 12'h001);
		setchk(POWER_CTRL_OFS, 32'h0000_0003, 12'h002);
		setchk(POWER_CTRL_OFS, 32'h0000_0000, 12'h004);
		$display("power states done");
		wr(IRQ_CLEAR_OFS, 32'h0000_0003, RESP_OKAY);
		rd(IRQ_STATUS_OFS, rv, RESP_OKAY); chk(rv, 32'h0000_0000);
		wr(IRQ_ENABLE_OFS, 32'h0000_0001, RESP_OKAY);
		poke(12'h800, 1'b1);
		rd(IRQ_STATUS_OFS, rv, RESP_OKAY); chk(rv, 32'h0000_0001);
		chk(irq_o, 32'h0000_0001);
		wr(IRQ_CLEAR_OFS, 32'h0000_0001, RESP_OKAY);
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i) chk(irq_o, 32'h0000_0000);
		wr(IRQ_ENABLE_OFS, 32'h0000_0000, RESP_OKAY);
		poke(12'h800, 1'b1);
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i) chk(irq_o, 32'h0000_0000);
		rd(IRQ_STATUS_OFS, rv, RESP_OKAY); chk(rv, 32'h0000_0001);
		rd(IRQ_CLEAR_OFS, rv, RESP_OKAY); chk(rv, 32'h0000_0000);
		$display("interrupt done");
		give_verdict();
	end
endmodule
